// file: logic/mdfs_regs.sv
// mdfs_regs: fault status and control register bank with serial port
// assumes: pins arrive asynchronously; clock far faster than sclk
//
// Contract
// RL1 - status1 bit7 latches thermal warning
// RL2 - status1 bit6 latches thermal shutdown
// RL3 - status1 bits5..0 per-switch overcurrent flags
// RL4 - status2 bit6 latches programming memory error
// RL5 - status2 bit5 latches regulator overcurrent
// RL6 - status2 bit4 latches regulator undervoltage
// RL7 - status2 bit3 latches pump undervoltage
// RL8 - status2 bit2 parity always reads zero
// RL9 - status2 bit1 latches clock framing error
// RL10 - status2 bit0 flags non-user address access
// RL11 - status1 at 1h, resets 00h, unwritable
// RL12 - status2 at 2h, resets 00h, bit7 zero
// RL13 - control registers at 3h..8h and Ch
// RL14 - control reset values 00,60,46,10,00,00,00
// RL15 - lock field password-only, clear bit write-one
// RL16 - short or long frame is framing error
// RL17 - address above Ch is invalid
// RL18 - flags latched until clear or sleep
// RL19 - clear bit returns to zero itself
`timescale 1ns/1ps
module mdfs_regs (
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // serial port pins
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       sdi,
  output logic            sdo_out_ff,
  output logic            sdo_oe_ff,
  // sleep pin
  input  wire logic       sleep_pin_n,
  // fault detectors, asynchronous levels
  input  wire logic [7:0] switch_fault_evt,
  input  wire logic [3:0] supply_fault_evt
);
  import mdfs_pkg::*;

  logic [15:0] s1_ff;          // first sync stage
  logic [15:0] s2_ff;          // second sync stage
  logic [2:0]  prev_ff;        // last sclk, cs, sleep
  logic [7:0]  sw_s;           // synced switch faults
  logic [3:0]  sup_s;          // synced supply faults
  logic        sclk_s;         // synced serial clock
  logic        cs_s;           // synced chip select
  logic        sdi_s;          // synced data in
  logic        sleep_s;        // synced sleep pin, low = sleep
  logic        sclk_fall;      // capture edge
  logic        sclk_rise;      // launch edge
  logic        cs_fall;        // frame start
  logic        cs_rise;        // frame end
  logic [4:0]  cnt_ff;         // sclk falls in frame
  logic [15:0] in_sr_ff;       // received word
  logic [5:0]  addr_ff;        // address once known
  logic [7:0]  hdr_ff;         // status byte of this frame
  mdfs_st_t    st_ff;          // frame tracking state
  logic        frame_ok;       // complete 16-bit frame
  logic [5:0]  f_addr;         // address of ended frame
  logic [7:0]  f_data;         // data of ended frame
  logic        wr_go;          // accepted write
  logic [2:0]  wr_idx;         // control slot written
  logic        locked;         // register lock engaged
  logic        clr_pulse_ff;   // clear request, one cycle
  logic        clr_all;        // clear source of flags
  logic [7:0]  stat1_ff;       // status register 1
  logic [7:0]  stat2_ff;       // status register 2
  logic [7:0]  ev2;            // status 2 event vector
  logic        frame_err_evt;  // framing error this cycle
  logic        addr_err_evt;   // address error this cycle
  logic [7:0]  ctrl_ff [NUM_CTRL];
  logic [7:0]  rd_data;        // read mux output
  logic        nxt_bit;        // next serial out bit

  // control slot from address; 7 means no slot
  function automatic logic [2:0] slot(input logic [5:0] a);
    logic [2:0] s;
    s = 3'h7;
    if (a >= ADDR_CTRL1 && a <= ADDR_CTRL6) begin
      s = 3'(a - ADDR_CTRL1);
    end else if (a == ADDR_CTRL10) begin
      s = 3'h6;
    end
    return s;
  endfunction : slot

  // reset value of a control slot
  function automatic logic [7:0] ctrl_rst(input int i);
    logic [7:0] v;
    v = RST_CTRL10;
    unique case (i)
      0: v = RST_CTRL1;
      1: v = RST_CTRL2;
      2: v = RST_CTRL3;
      3: v = RST_CTRL4;
      4: v = RST_CTRL5;
      5: v = RST_CTRL6;
      default: v = RST_CTRL10;
    endcase
    return v;
  endfunction : ctrl_rst

  // two-stage synchroniser for all pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
    end else if (ce) begin
      s1_ff <= {sleep_pin_n, sdi, chip_select_n, sclk, supply_fault_evt, switch_fault_evt};
      s2_ff <= s1_ff;
    end
  end

  // only the second stage is read from here on
  assign sw_s    = s2_ff[7:0];
  assign sup_s   = s2_ff[11:8];
  assign sclk_s  = s2_ff[12];
  assign cs_s    = s2_ff[13];
  assign sdi_s   = s2_ff[14];
  assign sleep_s = s2_ff[15];

  // edge history of the synced controls
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_ff <= 3'h6;
    end else if (ce) begin
      prev_ff <= {sleep_s, cs_s, sclk_s};
    end
  end

  // edges; sclk ignored while chip select is high
  assign sclk_fall = !cs_s && prev_ff[0] && !sclk_s;
  assign sclk_rise = !cs_s && !prev_ff[0] && sclk_s;
  assign cs_fall   = prev_ff[1] && !cs_s;
  assign cs_rise   = !prev_ff[1] && cs_s;

  // frame tracking state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= MDFS_IDLE;
    end else if (ce) begin
      unique case (st_ff)
        MDFS_IDLE: if (cs_fall) begin
          st_ff <= MDFS_SHFT;
        end
        MDFS_SHFT: if (cs_rise) begin
          st_ff <= MDFS_DONE;
        end
        MDFS_DONE: st_ff <= MDFS_IDLE;
        default:   st_ff <= MDFS_IDLE;
      endcase
    end
  end

  // bit counter saturates so overlong frames stay wrong
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff <= 5'h00;
    end else if (ce) begin
      if (cs_fall) begin
        cnt_ff <= 5'h00;
      end else if (sclk_fall && cnt_ff != CNT_SAT) begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  // receive shifter, msb first on falling sclk
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_sr_ff <= 16'h0000;
    end else if (ce && sclk_fall) begin
      in_sr_ff <= {in_sr_ff[14:0], sdi_s};
    end
  end

  // address held once the first seven bits are in
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_ff <= 6'h00;
    end else if (ce && cnt_ff == ADDR_CNT) begin
      addr_ff <= in_sr_ff[5:0];
    end
  end

  // frame decode at release of a tracked frame only
  assign frame_ok = cs_rise && st_ff == MDFS_SHFT && cnt_ff == FRAME_LEN;
  assign f_addr   = in_sr_ff[14:9];
  assign f_data   = in_sr_ff[7:0];
  assign wr_idx   = slot(f_addr);
  assign locked   = ctrl_ff[0][2:0] == LOCK_SHUT;
  // RL13 writes only reach control slots
  assign wr_go    = frame_ok && !in_sr_ff[15] && sleep_s && wr_idx != 3'h7 && (!locked || wr_idx == 3'h0);

  // RL16 wrong bit count on release
  assign frame_err_evt = cs_rise && cnt_ff != FRAME_LEN;
  // RL17 out-of-map address on a good frame
  assign addr_err_evt  = frame_ok && f_addr > ADDR_LAST;

  // control registers, one process per slot
  for (genvar i = 0; i < NUM_CTRL; i++) begin : g_ctrl
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        // RL14 power-up defaults
        ctrl_ff[i] <= ctrl_rst(i);
      end else if (ce) begin
        if (!sleep_s) begin
          // sleep also restores defaults
          ctrl_ff[i] <= ctrl_rst(i);
        end else if (wr_go && wr_idx == 3'(i)) begin
          if (i == 0) begin
            // RL15 lock field needs password value
            if (f_data[2:0] == LOCK_OPEN || f_data[2:0] == LOCK_SHUT) begin
              ctrl_ff[i] <= {5'h00, f_data[2:0]};
            end
          end else if (i == 1) begin
            // RL19 clear bit never stored
            ctrl_ff[i] <= {f_data[7:1], 1'b0};
          end else if (i == 2) begin
            ctrl_ff[i] <= {1'b0, f_data[6:0]};
          end else begin
            ctrl_ff[i] <= f_data;
          end
        end
      end
    end
  end

  // clear-fault command pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clr_pulse_ff <= 1'b0;
    end else if (ce) begin
      // RL15 writing one issues the clear
      clr_pulse_ff <= wr_go && wr_idx == 3'h1 && f_data[CLR_BIT];
    end
  end

  // sleep held low acts as the reset pulse
  assign clr_all = clr_pulse_ff || !sleep_s;

  // status register 1: sticky, set beats clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // RL11 resets clear, no write path
      stat1_ff <= RST_STAT;
    end else if (ce) begin
      // RL1 RL2 RL3 RL18 latch until cleared
      stat1_ff <= (clr_all ? RST_STAT : stat1_ff) | sw_s;
    end
  end

  // status 2 events; bits 7 and 2 are never set
  always_comb begin
    ev2            = 8'h00;
    // RL4 RL5 RL6 RL7 supply faults
    ev2[OTP_BIT]   = sup_s[3];
    ev2[ROCP_BIT]  = sup_s[2];
    ev2[RUV_BIT]   = sup_s[1];
    ev2[PUV_BIT]   = sup_s[0];
    // RL9 RL10 serial faults
    ev2[FRAME_BIT] = frame_err_evt;
    ev2[ADDR_BIT]  = addr_err_evt;
  end

  // status register 2: sticky, set beats clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // RL12 reset value
      stat2_ff <= RST_STAT;
    end else if (ce) begin
      // RL18 latch until cleared
      stat2_ff <= (clr_all ? RST_STAT : stat2_ff) | ev2;
    end
  end

  // read mux; holes and the summary register read zero
  always_comb begin
    rd_data = 8'h00;
    if (addr_ff == ADDR_STAT1) begin
      rd_data = stat1_ff;
    end else if (addr_ff == ADDR_STAT2) begin
      // RL8 RL12 parity and bit7 read zero
      rd_data = stat2_ff & 8'h7B;
    end else if (slot(addr_ff) != 3'h7) begin
      rd_data = ctrl_ff[slot(addr_ff)];
    end
  end

  // status byte captured at frame start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hdr_ff <= 8'h00;
    end else if (ce && cs_fall) begin
      hdr_ff <= {6'h00, |stat2_ff, |stat1_ff};
    end
  end

  // next serial bit: status byte, then register data
  always_comb begin
    nxt_bit = sdo_out_ff;
    if (cs_fall) begin
      nxt_bit = 1'b0;
    end else if (sclk_rise && cnt_ff < STAT_LEN) begin
      nxt_bit = hdr_ff[3'(4'h7 - cnt_ff[3:0])];
    end else if (sclk_rise && cnt_ff < FRAME_LEN) begin
      nxt_bit = rd_data[3'(4'hF - cnt_ff[3:0])];
    end
  end

  // serial out; open drain mode only drives low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sdo_out_ff <= 1'b0;
      sdo_oe_ff  <= 1'b0;
    end else if (ce) begin
      if (cs_s) begin
        sdo_out_ff <= 1'b0;
        sdo_oe_ff  <= 1'b0;
      end else begin
        sdo_out_ff <= nxt_bit;
        sdo_oe_ff  <= ctrl_ff[1][SDOPP_BIT] || !nxt_bit;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_warn_latch: assert property (ce && sw_s[WARN_BIT] |=> stat1_ff[WARN_BIT]) // RL1
    else $error("thermal warning not latched");
  chk_shut_latch: assert property (ce && sw_s[SHUT_BIT] |=> stat1_ff[SHUT_BIT]) // RL2
    else $error("thermal shutdown not latched");
  chk_switch_latch: assert property (ce |=> (stat1_ff & $past(sw_s)) == $past(sw_s)) // RL3
    else $error("switch overcurrent not latched");
  chk_otp_latch: assert property (ce && sup_s[3] |=> stat2_ff[OTP_BIT]) // RL4
    else $error("memory error not latched");
  chk_rocp_latch: assert property (ce && sup_s[2] |=> stat2_ff[ROCP_BIT]) // RL5
    else $error("regulator overcurrent not latched");
  chk_ruv_latch: assert property (ce && sup_s[1] |=> stat2_ff[RUV_BIT]) // RL6
    else $error("regulator undervoltage not latched");
  chk_puv_latch: assert property (ce && sup_s[0] |=> stat2_ff[PUV_BIT]) // RL7
    else $error("pump undervoltage not latched");
  chk_zero_bits: assert property (!stat2_ff[PAR_BIT] && !stat2_ff[RSVD_BIT]) // RL8
    else $error("parity or reserved bit set");
  chk_frame_err: assert property (ce && cs_rise && cnt_ff != FRAME_LEN |=> stat2_ff[FRAME_BIT]) // RL9
    else $error("framing error missed");
  chk_addr_err: assert property (ce && frame_ok && f_addr > ADDR_LAST |=> stat2_ff[ADDR_BIT]) // RL10
    else $error("address error missed");
  chk_stat_reset: assert property (disable iff (1'b0) !rst_n |=> stat1_ff == RST_STAT && stat2_ff == RST_STAT) // RL11
    else $error("status not reset");
  chk_ctrl_reset: assert property (disable iff (1'b0) !rst_n |=> ctrl_ff[1] == RST_CTRL2 && ctrl_ff[2] == RST_CTRL3) // RL14
    else $error("control defaults wrong");
  chk_lock_pw: assert property (ce && wr_go && wr_idx == 3'h0 && f_data[2:0] != LOCK_OPEN
                                && f_data[2:0] != LOCK_SHUT |=> $stable(ctrl_ff[0])) // RL15
    else $error("lock field took bad value");
  chk_clear_flags: assert property (ce && clr_pulse_ff && sw_s == 8'h00 |=> stat1_ff == 8'h00) // RL18
    else $error("clear did not empty status");
  chk_clear_self: assert property (ce && clr_pulse_ff |=> !clr_pulse_ff && !ctrl_ff[1][CLR_BIT]) // RL19
    else $error("clear bit stuck");

  cov_good_frame: cover property (frame_ok && !in_sr_ff[15]);
  cov_short_frame: cover property (frame_err_evt);
  cov_bad_addr: cover property (addr_err_evt);
  cov_clear_cmd: cover property (clr_pulse_ff);
endmodule : mdfs_regs

// file: logic/mdfs_pkg.sv
// mdfs_pkg: constants for the motor driver fault status bank
// assumes: 8-bit registers behind a 16-bit serial frame
package mdfs_pkg;
  // register addresses (6-bit serial address field)
  localparam logic [5:0] ADDR_IC     = 6'h00;
  localparam logic [5:0] ADDR_STAT1  = 6'h01;
  localparam logic [5:0] ADDR_STAT2  = 6'h02;
  localparam logic [5:0] ADDR_CTRL1  = 6'h03;
  localparam logic [5:0] ADDR_CTRL6  = 6'h08;
  localparam logic [5:0] ADDR_CTRL10 = 6'h0C;
  localparam logic [5:0] ADDR_LAST   = 6'h0C;
  // reset values
  localparam logic [7:0] RST_STAT    = 8'h00;
  localparam logic [7:0] RST_CTRL1   = 8'h00;
  localparam logic [7:0] RST_CTRL2   = 8'h60;
  localparam logic [7:0] RST_CTRL3   = 8'h46;
  localparam logic [7:0] RST_CTRL4   = 8'h10;
  localparam logic [7:0] RST_CTRL5   = 8'h00;
  localparam logic [7:0] RST_CTRL6   = 8'h00;
  localparam logic [7:0] RST_CTRL10  = 8'h00;
  localparam int         NUM_CTRL    = 7;
  // status register 1 field positions
  localparam int WARN_BIT  = 7;
  localparam int SHUT_BIT  = 6;
  // status register 2 field positions
  localparam int OTP_BIT   = 6;
  localparam int ROCP_BIT  = 5;
  localparam int RUV_BIT   = 4;
  localparam int PUV_BIT   = 3;
  localparam int PAR_BIT   = 2;
  localparam int FRAME_BIT = 1;
  localparam int ADDR_BIT  = 0;
  localparam int RSVD_BIT  = 7;
  // control field positions
  localparam int CLR_BIT   = 0;
  localparam int SDOPP_BIT = 5;
  localparam int C3RSV_BIT = 7;
  localparam logic [2:0] LOCK_OPEN = 3'h3;
  localparam logic [2:0] LOCK_SHUT = 3'h6;
  // frame geometry
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CNT_SAT   = 5'h11;
  localparam logic [4:0] ADDR_CNT  = 5'h07;
  localparam logic [4:0] STAT_LEN  = 5'h08;
  // synchroniser reset: sleep_n and chip select idle high
  localparam logic [15:0] SYNC_RST = 16'hA000;
  // frame tracking states
  typedef enum logic [1:0] {
    MDFS_IDLE = 2'b00,
    MDFS_SHFT = 2'b01,
    MDFS_DONE = 2'b11
  } mdfs_st_t;
endpackage : mdfs_pkg

// file: verification/mdfs_spi_host.sv
// mdfs_spi_host: behavioural serial controller facing the fault status bank
// assumes: a 100 MHz device clock paces every edge it makes
`timescale 1ns/1ps
module mdfs_spi_host (
  // device clock used as time base
  input  wire logic clock,
  // serial pins toward the device
  output logic      sclk,
  output logic      chip_select_n,
  output logic      sdi,
  // device data out, value and enable
  input  wire logic sdo_val,
  input  wire logic sdo_en
);
  logic sdo_line; // released line floats high on its pull-up
  assign sdo_line = sdo_en ? sdo_val : 1'b1;
  // clock parked low, select idle high
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end
  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // one frame of n clocks; half periods of 6 clocks beat the sync delay
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'hFFFF;
    chip_select_n = 1'b0;
    tick(8);
    // commanded frame length
    // data moves with the rise so it stands at the capturing fall
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdi = (i < 16) ? w[15 - i] : 1'b0;
      tick(6);
      if (i < 16) r[15 - i] = sdo_line;
      sclk = 1'b0;
      tick(6);
    end
    tick(6);
    chip_select_n = 1'b1;
    // data line no longer valid, so show the inverse
    sdi = ~sdi;
    tick(8);
  endtask : xfer
endmodule : mdfs_spi_host

// file: verification/tb_top.sv
// tb_top: self-checking bench for the fault status bank
// assumes: the serial controller model drives every frame
`timescale 1ns/1ps
module tb_top;
  import mdfs_pkg::*;
  logic        clock;             // 100 MHz
  logic        rst_n;             // sync reset
  logic        ce;                // high except in t_ce
  logic        sleep_pin_n;       // sleep request
  logic        sclk;              // serial clock
  logic        chip_select_n;     // frame select
  logic        sdi;               // serial in
  logic        sdo_out_ff;        // serial out value
  logic        sdo_oe_ff;         // serial out enable
  logic [7:0]  switch_fault_evt;  // thermal and switch faults
  logic [3:0]  supply_fault_evt;  // supply faults
  int          n_fail;            // mismatches
  int          cmp_count;         // comparisons
  mdfs_regs uut (.clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdi(sdi), .sdo_out_ff(sdo_out_ff), .sdo_oe_ff(sdo_oe_ff), .sleep_pin_n(sleep_pin_n),
    .switch_fault_evt(switch_fault_evt), .supply_fault_evt(supply_fault_evt));
  mdfs_spi_host host (.clock(clock), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
    .sdo_val(sdo_out_ff), .sdo_en(sdo_oe_ff));
  initial clock = 1'b0;
  always #5 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    host.xfer({1'b1, a, 9'h000}, 16, q);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [15:0] q);
    host.xfer({1'b0, a, 1'b0, d}, 16, q);
  endtask : wr
  // self-clearing bit wipes every latched flag
  task automatic clr();
    logic [15:0] q;
    wr(6'h04, 8'h61, q);
  endtask : clr
  // pulse fault inputs, then drop them so a clear can win
  task automatic pulse(input logic [7:0] s, input logic [3:0] p);
    switch_fault_evt = s;
    supply_fault_evt = p;
    tick(4);
    switch_fault_evt = 8'h00;
    supply_fault_evt = 4'h0;
    tick(4);
  endtask : pulse
  task automatic t_reset();
    logic [15:0] q;
    logic [5:0]  ad [9];
    logic [7:0]  rv [9];
    ad = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0C};
    rv = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h46, 8'h10, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 9; k++) begin
      rd(ad[k], q);
      chk("reset value", {8'h00, rv[k]}, q);
    end
    $display("t_reset done");
  endtask : t_reset
  // clock enable low hides a fault pulse from every flop
  task automatic t_ce();
    logic [15:0] q;
    ce = 1'b0;
    pulse(8'h40, 4'h0);
    ce = 1'b1;
    tick(4);
    rd(6'h01, q);
    chk("frozen flags", 16'h0000, q);
    $display("t_ce done");
  endtask : t_ce
  task automatic t_flags();
    logic [15:0] q;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 4'h0);
      rd(6'h01, q);
      chk("status one", {8'h01, 8'h01 << i}, q);
      rd(6'h01, q);
      chk("status one held", {8'h01, 8'h01 << i}, q);
      clr();
      rd(6'h01, q);
      chk("status one cleared", 16'h0000, q);
    end
    for (int k = 0; k < 4; k++) begin
      pulse(8'h00, 4'h1 << k);
      rd(6'h02, q);
      chk("status two", {8'h02, 8'h08 << k}, q);
      clr();
      rd(6'h02, q);
      chk("status two cleared", 16'h0000, q);
    end
    rd(6'h04, q);
    chk("clear bit", 16'h0060, q);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_ro();
    logic [15:0] q;
    pulse(8'h01, 4'h1);
    wr(6'h01, 8'hFF, q);
    rd(6'h01, q);
    chk("status one write", 16'h0301, q);
    wr(6'h02, 8'hFF, q);
    host.xfer(16'h8500, 16, q);
    chk("status two write", 16'h0308, q);
    clr();
    $display("t_ro done");
  endtask : t_ro
  task automatic t_frame();
    logic [15:0] q;
    host.xfer(16'h0A12, 8, q);
    rd(6'h02, q);
    chk("short frame", 16'h0202, q);
    rd(6'h05, q);
    chk("short frame write", 16'h0246, q);
    clr();
    host.xfer(16'h0A12, 17, q);
    rd(6'h02, q);
    chk("long frame", 16'h0202, q);
    clr();
    rd(6'h02, q);
    chk("frame cleared", 16'h0000, q);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_addr();
    logic [15:0] q;
    rd(6'h0D, q);
    rd(6'h02, q);
    chk("address past end", 16'h0201, q);
    clr();
    rd(6'h09, q);
    chk("gap address", 16'h0000, q);
    rd(6'h02, q);
    chk("no address fault", 16'h0000, q);
    wr(6'h3F, 8'h00, q);
    rd(6'h02, q);
    chk("top address", 16'h0201, q);
    clr();
    $display("t_addr done");
  endtask : t_addr
  task automatic t_lock();
    logic [15:0] q;
    wr(6'h03, 8'h06, q);
    wr(6'h05, 8'h12, q);
    chk("old data", 16'h0046, q);
    rd(6'h05, q);
    chk("locked write", 16'h0046, q);
    wr(6'h03, 8'h05, q);
    rd(6'h03, q);
    chk("lock code", 16'h0006, q);
    wr(6'h03, 8'h03, q);
    wr(6'h05, 8'h12, q);
    rd(6'h05, q);
    chk("unlocked write", 16'h0012, q);
    // open drain output: ones come from the pull-up
    wr(6'h04, 8'h40, q);
    wr(6'h05, 8'h46, q);
    chk("open drain", 16'h0012, q);
    wr(6'h04, 8'h60, q);
    rd(6'h04, q);
    chk("mode back", 16'h0060, q);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_sleep();
    logic [15:0] q;
    wr(6'h05, 8'h12, q);
    pulse(8'h80, 4'h0);
    sleep_pin_n = 1'b0;
    tick(8);
    sleep_pin_n = 1'b1;
    tick(8);
    rd(6'h01, q);
    chk("sleep flags", 16'h0000, q);
    rd(6'h05, q);
    chk("sleep defaults", 16'h0046, q);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // about 100 frames of roughly 220 clocks each
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    $display("Error watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sleep_pin_n = 1'b1;
    switch_fault_evt = 8'h00;
    supply_fault_evt = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    tick(4);
    rst_n = 1'b1;
    tick(2);
    t_reset();
    t_ce();
    t_flags();
    t_ro();
    t_frame();
    t_addr();
    t_lock();
    t_sleep();
    close_out();
  end
endmodule : tb_top
